// [rtl/ldc_pkg.sv]
package ldc_pkg;
    // Display timing, in display clock cycles.
    localparam int FLASH_PERIOD_CYC = 28672;
    localparam int SELFTEST_CYC = 262144;
    localparam int SEQ_CYC = 3;
    localparam logic [1:0] SEQ_LOAD = 2'h3;
    localparam int SYNC_MARGIN_CYC = 5;
    // Brightness modulation frame: last slot of the PWM count.
    localparam logic [3:0] PWM_LAST = 4'he;
    // Control word bit positions and reset value.
    localparam int CTL_BRIGHT_MSB = 2;
    localparam int CTL_FLASH_EN = 3;
    localparam int CTL_BLINK = 4;
    localparam int CTL_PASS = 5;
    localparam int CTL_TEST = 6;
    localparam int CTL_CLEAR = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam logic [7:0] USER_CHARACTER_ADDR_RESET = 8'h00;
    localparam logic [7:0] USER_CHARACTER_ADDR_TEST_END = 8'hff;
    // Targets selected by the attribute select level and address lines 4:3.
    localparam logic [2:0] RGN_USER_CHARACTER_ADDR = 3'h0;
    localparam logic [2:0] RGN_USER_CHARACTER_RAM = 3'h1;
    localparam logic [2:0] RGN_CTRL = 3'h2;
    localparam logic [2:0] RGN_CHAR = 3'h3;
    localparam logic [2:0] RGN_FLASH = 3'h4;
    // Decoder memory checked by the first self-test phase.
    localparam int ROM_DEPTH = 128;
    // Host bus sequencing.
    localparam int H_SETUP_CYC = 2;
    localparam int H_STROBE_CYC = 8;
    localparam int H_HOLD_CYC = 2;
    localparam int H_RST_LOW_CYC = 4;
    // APB register offsets and command fields.
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_RESET = 12'h008;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_ATTR_SEL = 13;
    localparam int CMD_READ = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DATA_LSB = 8;

    function automatic logic [7:0] ldc_rom_word(input logic [6:0] idx);
        return {idx[2:0] ^ idx[6:4], idx[4:0]} ^ {1'b0, idx};
    endfunction : ldc_rom_word

    function automatic logic [7:0] ldc_rom_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < ROM_DEPTH; i++) begin
            s = s + ldc_rom_word(7'(i));
        end
        return s;
    endfunction : ldc_rom_sum

    localparam logic [7:0] ROM_SUM = ldc_rom_sum();
endpackage : ldc_pkg

// [rtl/ldc_if.sv]
`timescale 1ns/100ps
interface ldc_if;
    logic rst_n;
    logic ce_n;
    logic wr_n;
    logic rd_n;
    logic attribute_select_n;
    logic [4:0] addr;
    logic [7:0] host_dout;
    logic host_oe;
    logic [7:0] dev_dout;
    logic dev_oe;
    logic [7:0] data;

    // Pulled-up data bus: whichever end enables its driver owns it.
    assign data = host_oe ? host_dout : (dev_oe ? dev_dout : 8'hff);

    modport display (
        input rst_n, ce_n, wr_n, rd_n, attribute_select_n, addr, data,
        output dev_dout, dev_oe
    );
    modport host (
        output rst_n, ce_n, wr_n, rd_n, attribute_select_n, addr, host_dout, host_oe,
        input data
    );
endinterface : ldc_if

// [rtl/ldc_display.sv]
`timescale 1ns/100ps
module ldc_display #(
    parameter int FLASH_PERIOD = ldc_pkg::FLASH_PERIOD_CYC,
    parameter int SELFTEST_LEN = ldc_pkg::SELFTEST_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host bus
    ldc_if.display bus,
    // Display drive
    output logic [7:0] digit_lit,
    output logic [63:0] char_codes,
    output logic [1:0] test_pattern,
    output logic [3:0] user_character_slot,
    output logic busy
);
    localparam int FB_W = $clog2(FLASH_PERIOD);
    localparam int ST_W = $clog2(SELFTEST_LEN + 1);
    localparam logic [FB_W-1:0] FB_LAST = FB_W'(FLASH_PERIOD - 1);
    localparam logic [FB_W-1:0] FB_HALF = FB_W'(FLASH_PERIOD / 2);
    localparam logic [ST_W-1:0] ST_LAST = ST_W'(SELFTEST_LEN - 1);
    localparam logic [ST_W-1:0] ST_ROM = ST_W'(ldc_pkg::ROM_DEPTH);
    localparam logic [ST_W-1:0] ST_MID =
        ST_W'(ldc_pkg::ROM_DEPTH + (SELFTEST_LEN - ldc_pkg::ROM_DEPTH) / 2);

    function automatic logic [2:0] region(input logic sel_n, input logic [4:0] a);
        return sel_n ? {1'b0, a[4:3]} : ldc_pkg::RGN_FLASH;
    endfunction : region

    function automatic logic [3:0] duty(input logic [2:0] code);
        unique case (code)
            3'h0: return 4'hf;
            3'h1: return 4'hc;
            3'h2: return 4'h8;
            3'h3: return 4'h6;
            3'h4: return 4'h4;
            3'h5: return 4'h3;
            3'h6: return 4'h2;
            3'h7: return 4'h0;
        endcase
    endfunction : duty

    logic [17:0] sync1, sync2;
    logic s_rst_n, s_ce_n, s_wr_n, s_rd_n, s_attr_sel_n, l_attr_sel_n;
    logic wr_act, rd_act, wr_prev, commit, seq_is_clear, clear_done, in_reset, fill_now;
    logic st_run, st_done, off_phase;
    logic [4:0] s_addr, l_addr;
    logic [7:0] s_data, l_data, ctrl, flash_ram, user_character_addr, cksum, rd_data;
    logic [7:0] char_ram [8];
    logic [2:0] l_rgn;
    logic [1:0] seq_cnt;
    logic [3:0] pwm_cnt;
    logic [ST_W-1:0] st_cnt;
    logic [FB_W-1:0] fb_cnt;

    // Every pin passes two flops before any decode looks at it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= {bus.rst_n, bus.ce_n, bus.wr_n, bus.rd_n,
                      bus.attribute_select_n, bus.addr, bus.data};
            sync2 <= sync1;
        end
    end

    assign {s_rst_n, s_ce_n, s_wr_n, s_rd_n, s_attr_sel_n, s_addr, s_data} = sync2;
    assign in_reset = ~s_rst_n;
    assign wr_act = ~s_ce_n & ~s_wr_n & s_rd_n;
    assign rd_act = ~s_ce_n & ~s_rd_n & s_wr_n;
    assign busy = in_reset | (seq_cnt != 2'h0) | st_run;
    // The write lands when the strobe ends, so a slow strobe edge cannot half-write.
    assign commit = wr_prev & ~wr_act & ~busy;
    assign l_rgn = region(l_attr_sel_n, l_addr);
    assign clear_done = seq_is_clear & (seq_cnt == 2'h1);
    assign st_done = st_run & (st_cnt == ST_LAST);
    assign fill_now = in_reset | clear_done | st_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_prev <= 1'b0;
            l_addr <= 5'h00;
            l_attr_sel_n <= 1'b1;
            l_data <= 8'h00;
        end else begin
            wr_prev <= wr_act;
            if (wr_act) begin
                l_addr <= s_addr;
                l_attr_sel_n <= s_attr_sel_n;
                l_data <= s_data;
            end
        end
    end

    // Reset and clear sequencer: three cycles after release or request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cnt <= 2'h0;
            seq_is_clear <= 1'b0;
        end else if (in_reset) begin
            seq_cnt <= ldc_pkg::SEQ_LOAD;
            seq_is_clear <= 1'b0;
        end else if (commit && l_rgn == ldc_pkg::RGN_CTRL && l_data[ldc_pkg::CTL_CLEAR]) begin
            seq_cnt <= ldc_pkg::SEQ_LOAD;
            seq_is_clear <= 1'b1;
        end else if (seq_cnt != 2'h0) begin
            seq_cnt <= seq_cnt - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ldc_pkg::CTL_RESET;
        end else if (in_reset) begin
            ctrl <= ldc_pkg::CTL_RESET;
        end else if (st_done) begin
            ctrl <= ctrl & (8'h01 << ldc_pkg::CTL_PASS);
        end else begin
            if (commit && l_rgn == ldc_pkg::RGN_CTRL) begin
                ctrl <= l_data;
                ctrl[ldc_pkg::CTL_PASS] <= ctrl[ldc_pkg::CTL_PASS];
            end else if (clear_done) begin
                ctrl[ldc_pkg::CTL_CLEAR] <= 1'b0;
            end
            if (st_run && st_cnt == ST_ROM) begin
                ctrl[ldc_pkg::CTL_PASS] <= (cksum == ldc_pkg::ROM_SUM);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_ram <= 8'h00;
        end else if (fill_now) begin
            flash_ram <= 8'h00;
        end else if (commit && l_rgn == ldc_pkg::RGN_FLASH) begin
            flash_ram[l_addr[2:0]] <= l_data[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                char_ram[i] <= ldc_pkg::BLANK_CHAR;
            end
        end else if (fill_now) begin
            for (int i = 0; i < 8; i++) begin
                char_ram[i] <= ldc_pkg::BLANK_CHAR;
            end
        end else if (commit && l_rgn == ldc_pkg::RGN_CHAR) begin
            char_ram[l_addr[2:0]] <= l_data;
        end
    end

    // User character memory itself is not held here; its address is.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_character_addr <= ldc_pkg::USER_CHARACTER_ADDR_RESET;
        end else if (st_done) begin
            user_character_addr <= ldc_pkg::USER_CHARACTER_ADDR_TEST_END;
        end else if (commit && l_rgn == ldc_pkg::RGN_USER_CHARACTER_ADDR) begin
            user_character_addr <= l_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_run <= 1'b0;
            st_cnt <= '0;
            cksum <= 8'h00;
        end else if (in_reset || st_done) begin
            st_run <= 1'b0;
        end else if (commit && l_rgn == ldc_pkg::RGN_CTRL && l_data[ldc_pkg::CTL_TEST]) begin
            st_run <= 1'b1;
            st_cnt <= '0;
            cksum <= 8'h00;
        end else if (st_run) begin
            st_cnt <= st_cnt + 1'b1;
            if (st_cnt < ST_ROM) begin
                cksum <= cksum + ldc_pkg::ldc_rom_word(st_cnt[6:0]);
            end
        end
    end

    // One counter serves flash and blink, so both keep the same phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_cnt <= '0;
        end else if (in_reset || fb_cnt == FB_LAST) begin
            fb_cnt <= '0;
        end else begin
            fb_cnt <= fb_cnt + 1'b1;
        end
    end

    assign off_phase = fb_cnt >= FB_HALF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt <= 4'h0;
        end else if (pwm_cnt == ldc_pkg::PWM_LAST) begin
            pwm_cnt <= 4'h0;
        end else begin
            pwm_cnt <= pwm_cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digit_lit <= 8'h00;
            test_pattern <= 2'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                digit_lit[i] <= st_run | (~in_reset
                    & (pwm_cnt < duty(ctrl[ldc_pkg::CTL_BRIGHT_MSB:0]))
                    & ~(ctrl[ldc_pkg::CTL_BLINK] & off_phase)
                    & ~(ctrl[ldc_pkg::CTL_FLASH_EN] & flash_ram[i] & off_phase));
            end
            // Decided one count early, so the registered patterns split the test exactly.
            test_pattern <= (st_run && !st_done && !in_reset && st_cnt >= ST_ROM - 1'b1)
                ? ((st_cnt < ST_MID - 1'b1) ? 2'h1 : 2'h2) : 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else begin
            unique case (region(s_attr_sel_n, s_addr))
                ldc_pkg::RGN_FLASH: rd_data <= {7'h00, flash_ram[s_addr[2:0]]};
                ldc_pkg::RGN_USER_CHARACTER_ADDR: rd_data <= user_character_addr;
                ldc_pkg::RGN_CTRL: rd_data <= ctrl;
                ldc_pkg::RGN_CHAR: rd_data <= char_ram[s_addr[2:0]];
                default: rd_data <= 8'h00;
            endcase
        end
    end

    assign bus.dev_dout = rd_data;
    assign bus.dev_oe = rd_act;
    assign user_character_slot = user_character_addr[3:0];

    for (genvar g = 0; g < 8; g++) begin : g_codes
        assign char_codes[g*8 +: 8] = char_ram[g];
    end
endmodule : ldc_display

// [rtl/ldc_host.sv]
`timescale 1ns/100ps
module ldc_host #(
    parameter int SELFTEST_LEN = ldc_pkg::SELFTEST_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Display bus
    ldc_if.host bus
);
    localparam int CW = $clog2(SELFTEST_LEN + ldc_pkg::SYNC_MARGIN_CYC + 1);
    localparam logic [CW-1:0] GUARD_SEQ =
        CW'(ldc_pkg::SEQ_CYC + ldc_pkg::SYNC_MARGIN_CYC);
    localparam logic [CW-1:0] GUARD_TEST =
        CW'(SELFTEST_LEN + ldc_pkg::SYNC_MARGIN_CYC);

    typedef enum logic [2:0] {
        LDC_IDLE, LDC_SETUP, LDC_STROBE, LDC_HOLD, LDC_RST, LDC_GUARD
    } ldc_hstate_t;

    ldc_hstate_t state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] guard;
    logic is_read;
    logic [7:0] rd_byte;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic apb_wr;
    logic apb_setup;
    logic mapped;

    assign apb_wr = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign mapped = paddr == ldc_pkg::APB_CMD || paddr == ldc_pkg::APB_STATUS
        || paddr == ldc_pkg::APB_RESET;
    // Read data and error are prepared in the setup cycle.
    assign pready = psel & penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= ~mapped;
            prdata <= 32'h0000_0000;
            if (paddr == ldc_pkg::APB_STATUS) begin
                prdata[ldc_pkg::STAT_BUSY] <= state != LDC_IDLE;
                prdata[ldc_pkg::STAT_DATA_LSB +: 8] <= rd_byte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_s1 <= 8'hff;
            data_s2 <= 8'hff;
        end else begin
            data_s1 <= bus.data;
            data_s2 <= data_s1;
        end
    end

    // Commands arriving while busy are dropped; software polls the busy bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= LDC_IDLE;
            cnt <= '0;
            guard <= '0;
            is_read <= 1'b0;
            rd_byte <= 8'h00;
            bus.rst_n <= 1'b1;
            bus.ce_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.attribute_select_n <= 1'b1;
            bus.addr <= 5'h00;
            bus.host_dout <= 8'h00;
            bus.host_oe <= 1'b0;
        end else begin
            unique case (state)
                LDC_IDLE: begin
                    if (apb_wr && paddr == ldc_pkg::APB_RESET) begin
                        bus.rst_n <= 1'b0;
                        bus.ce_n <= 1'b1;
                        cnt <= CW'(ldc_pkg::H_RST_LOW_CYC - 1);
                        guard <= GUARD_SEQ;
                        state <= LDC_RST;
                    end else if (apb_wr && paddr == ldc_pkg::APB_CMD) begin
                        is_read <= pwdata[ldc_pkg::CMD_READ];
                        bus.addr <= pwdata[ldc_pkg::CMD_ADDR_LSB +: 5];
                        bus.attribute_select_n <= pwdata[ldc_pkg::CMD_ATTR_SEL];
                        bus.host_dout <= pwdata[7:0];
                        bus.host_oe <= ~pwdata[ldc_pkg::CMD_READ];
                        guard <= '0;
                        if (!pwdata[ldc_pkg::CMD_READ] && pwdata[ldc_pkg::CMD_ATTR_SEL]
                            && pwdata[ldc_pkg::CMD_ADDR_LSB +: 5] == 5'h10) begin
                            if (pwdata[ldc_pkg::CTL_TEST]) begin
                                guard <= GUARD_TEST;
                            end else if (pwdata[ldc_pkg::CTL_CLEAR]) begin
                                guard <= GUARD_SEQ;
                            end
                        end
                        cnt <= CW'(ldc_pkg::H_SETUP_CYC - 1);
                        state <= LDC_SETUP;
                    end
                end
                LDC_SETUP: begin
                    if (cnt == '0) begin
                        bus.ce_n <= 1'b0;
                        bus.wr_n <= is_read;
                        bus.rd_n <= ~is_read;
                        cnt <= CW'(ldc_pkg::H_STROBE_CYC - 1);
                        state <= LDC_STROBE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                LDC_STROBE: begin
                    if (cnt == '0) begin
                        if (is_read) begin
                            rd_byte <= data_s2;
                        end
                        bus.ce_n <= 1'b1;
                        bus.wr_n <= 1'b1;
                        bus.rd_n <= 1'b1;
                        cnt <= CW'(ldc_pkg::H_HOLD_CYC - 1);
                        state <= LDC_HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                LDC_HOLD: begin
                    if (cnt == '0) begin
                        bus.host_oe <= 1'b0;
                        cnt <= guard;
                        state <= LDC_GUARD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                LDC_RST: begin
                    if (cnt == '0) begin
                        bus.rst_n <= 1'b1;
                        cnt <= guard;
                        state <= LDC_GUARD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                LDC_GUARD: begin
                    if (cnt == '0) begin
                        state <= LDC_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : ldc_host

// [verif/ldc_bus_asserts.sv]
`timescale 1ns/100ps
module ldc_bus_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Display bus
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic attribute_select_n,
    input wire logic [4:0] addr,
    input wire logic host_oe,
    input wire logic dev_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_strobe;
        !ce_n [*8] ##1 ce_n;
    endsequence
    sequence s_rst_pulse;
        !rst_n [*4] ##1 rst_n;
    endsequence

    chk_one_driver: assert property (!(host_oe && dev_oe))
        else $error("data bus driven from both ends");
    chk_write_drive: assert property (!ce_n && !wr_n |-> host_oe && rd_n)
        else $error("write strobe without host data");
    chk_read_release: assert property (!ce_n && !rd_n |-> wr_n && !host_oe)
        else $error("read strobe while host drives");
    chk_dev_answer: assert property ($rose(dev_oe) |-> !ce_n && !rd_n)
        else $error("device drove bus outside a read");
    chk_strobe_width: assert property ($fell(ce_n) |-> s_strobe)
        else $error("strobe not eight cycles");
    chk_addr_hold: assert property (!ce_n |-> $stable(addr) && $stable(attribute_select_n))
        else $error("address moved during strobe");
    chk_ce_in_reset: assert property (!rst_n |-> ce_n)
        else $error("chip select low during reset");
    chk_rst_pulse: assert property ($fell(rst_n) |-> s_rst_pulse)
        else $error("reset pulse not four cycles");
    // The display needs its reset sequence to finish before any access.
    chk_reset_quiet: assert property ($rose(rst_n) |-> ce_n [*8])
        else $error("access too soon after reset");
endmodule : ldc_bus_asserts

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
    // Short counts keep the run brief; expectations follow them.
    localparam int FP = 64;
    localparam int STL = 512;
    typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} ldc_row_t;
    ldc_row_t rows [4] = '{'{5'h18, 8'h41, 8'h41}, '{5'h1f, 8'h7e, 8'h7e},
        '{5'h10, 8'h2a, 8'h0a}, '{5'h10, 8'h13, 8'h13}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] digit_lit;
    logic [63:0] char_codes;
    logic [1:0] test_pattern;
    logic [3:0] user_character_slot;
    int fails, checked, offc [8], pc [4];

    ldc_if bus_if ();
    ldc_display #(.FLASH_PERIOD(FP), .SELFTEST_LEN(STL)) ldc_display_inst (
        .pclk(pclk), .presetn(presetn), .bus(bus_if.display), .digit_lit(digit_lit),
        .char_codes(char_codes), .test_pattern(test_pattern),
        .user_character_slot(user_character_slot),
        .busy(busy));
    ldc_host #(.SELFTEST_LEN(STL)) ldc_host_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus_if.host));
    ldc_bus_asserts ldc_bus_asserts_inst (
        .pclk(pclk), .presetn(presetn), .rst_n(bus_if.rst_n), .ce_n(bus_if.ce_n),
        .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr),
        .attribute_select_n(bus_if.attribute_select_n), .host_oe(bus_if.host_oe),
        .dev_oe(bus_if.dev_oe));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("TB: %0d compares, %0d mismatches", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle();
        do apb(1'b0, ldc_pkg::APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
    endtask : idle

    task automatic cmd(input logic r, input logic f, input logic [4:0] a, input logic [7:0] d);
        apb(1'b1, ldc_pkg::APB_CMD, {15'h0, r, 2'h0, f, a, d});
        idle();
    endtask : cmd

    // Whole flash periods are counted, so the phase of the flash counter does not matter.
    task automatic measure();
        offc = '{default: 0};
        repeat (FP) begin
            @(negedge pclk);
            foreach (offc[i]) if (digit_lit[i] !== 1'b1) offc[i]++;
        end
    endtask : measure

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(negedge pclk) if (busy === 1'b1) pc[test_pattern]++;

    // About twenty commands with polling plus one self-test, with a wide margin.
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        final_report();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            cmd(1'b0, 1'b1, rows[i].a, rows[i].d);
            cmd(1'b1, 1'b1, rows[i].a, 8'h00);
            check("row read", rd[15:8], rows[i].e);
        end
        check("row chars", {char_codes[63:56], char_codes[7:0]}, 16'h7e41);
        $display("TB: row tests done");
        cmd(1'b0, 1'b1, 5'h10, 8'h08);
        cmd(1'b0, 1'b0, 5'h19, 8'hff);
        measure();
        check("flash d1", offc[1], FP / 2);
        check("flash d0", offc[0], 0);
        cmd(1'b0, 1'b1, 5'h10, 8'h00);
        measure();
        check("flash off", offc[1], 0);
        cmd(1'b0, 1'b1, 5'h10, 8'h18);
        measure();
        check("blink d0", offc[0], FP / 2);
        cmd(1'b0, 1'b1, 5'h10, 8'h07);
        measure();
        check("blank", offc[7], FP);
        $display("TB: flash tests done");
        cmd(1'b0, 1'b1, 5'h10, 8'h88);
        cmd(1'b1, 1'b1, 5'h10, 8'h00);
        check("clear ctrl", rd[15:8], 8'h08);
        check("clear chars", char_codes, {8{8'h20}});
        measure();
        check("clear flash", offc[1], 0);
        $display("TB: clear test done");
        pc = '{default: 0};
        cmd(1'b0, 1'b1, 5'h10, 8'h40);
        cmd(1'b1, 1'b1, 5'h10, 8'h00);
        check("test ctrl", rd[15:8], 8'h20);
        check("test slot", user_character_slot, 4'hf);
        check("test chars", char_codes, {8{8'h20}});
        check("test halves", pc[1], (STL - ldc_pkg::ROM_DEPTH) / 2);
        check("test span", pc[1] + pc[2], STL - ldc_pkg::ROM_DEPTH);
        $display("TB: self-test done");
        cmd(1'b0, 1'b1, 5'h00, 8'h35);
        cmd(1'b0, 1'b1, 5'h1a, 8'h55);
        apb(1'b1, ldc_pkg::APB_RESET, 32'h1);
        idle();
        cmd(1'b1, 1'b1, 5'h10, 8'h00);
        check("reset ctrl", rd[15:8], 8'h00);
        check("reset chars", char_codes, {8{8'h20}});
        check("reset slot", user_character_slot, 4'h5);
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped", err, 1'b1);
        $display("TB: reset test done");
        final_report();
    end
endmodule : testbench
